//--- logic/dpsf_regs.vh
// Constants for the semaphore flag host controller
`ifndef DPSF_REGS_VH
`define DPSF_REGS_VH
`define DPSF_ADDR_W 3
`define DPSF_DATA_W 16
`define DPSF_NUM_FLAGS 8
`define DPSF_SETUP_NS 50
`define DPSF_STROBE_NS 100
`define DPSF_CLK_NS 50
`define DPSF_SETUP_CYC ((`DPSF_SETUP_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
`define DPSF_STROBE_CYC ((`DPSF_STROBE_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
`define DPSF_CMD_ACQUIRE 2'h0
`define DPSF_CMD_RELEASE 2'h1
`define DPSF_CMD_POLL 2'h2
`define DPSF_CMD_INIT 2'h3
`define DPSF_LAST_FLAG 3'h7
`define DPSF_SYNC_CYC 2
`endif

//--- logic/dpsf_sync.v
// Two-stage synchroniser for the flag read-back bit
`include "dpsf_regs.vh"
module dpsf_sync (
  input wire i_clk,
  input wire i_rstn,
  input wire i_d,
  output reg o_q
);
  reg meta;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= 1'b1;
      o_q <= 1'b1;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // dpsf_sync

//--- logic/dpsf_host.v
// Host controller driving one port of a dual-port semaphore flag space
// Function
// R1: Device replicates flag on all data bits; host samples the lowest bit.
// R2: Device latches read value when flag select and output enable activate.
// R3: Device holds captured read value stable during a read.
// R4: Host deasserts flag select and output enable between successive poll reads.
// R5: Host acquires by writing zero first, then reading back.
// R6: Device records zero request on held flag, still reporting one.
// R7: First request latch presenting zero owns the flag.
// R8: Ownership stays until owner writes one.
// R9: Pending request takes ownership when owner releases.
// R10: New owner stays low until it writes one.
// R11: After failed request host rereads or writes one to withdraw.
// R12: Simultaneous requests grant exactly one side.
// R13: Earlier requester wins.
// R14: True ties may go to either port.
// R15: Device latches are undefined at power-up.
// R16: Host writes one to every flag at start-up.
// R17: Only three low address lines select a flag, with flag select and strobe.
// R18: Device uses only the lowest data bit on writes.
// R19: Zero to free flag reads zero here, one on the other side.
// R20: Owner writing one frees the flag unless a request is pending.
`include "dpsf_regs.vh"
module dpsf_host (
  input wire I_CORE_CLK,
  input wire I_RSTN,
  input wire I_REQ,
  input wire [1:0] I_CMD,
  input wire [2:0] I_FLAG,
  input wire [15:0] I_DATA_IN,
  output reg O_FLAG_SPACE_SELECT_N,
  output reg O_OE_N,
  output reg O_RW_N,
  output reg [2:0] O_ADDR,
  output reg [15:0] O_DATA_OUT,
  output reg O_DATA_OE,
  output reg O_BUSY,
  output reg O_DONE,
  output reg O_GRANTED,
  output reg O_INIT_DONE
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_INIT = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_WSET = 3'h2;
  localparam ST_WSTB = 3'h3;
  localparam ST_RSET = 3'h4;
  localparam ST_RSTB = 3'h5;
  localparam ST_GAP = 3'h6;

  reg [2:0] state;
  reg [1:0] cmd;
  reg [2:0] cnt;
  reg [2:0] timer;
  reg do_read;
  wire flag_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Only the lowest data bit matters; replicated by the device anyway
  dpsf_sync u_sync (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .i_d(I_DATA_IN[0]),
    .o_q(flag_bit)
  ); // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts stay below eight, so three timer bits suffice
  function [2:0] cyc;
    input integer n;
    begin
      cyc = n[2:0];
    end
  endfunction

  // Zero and one both end a phase, so a zero load cannot stall a state
  function expired;
    input [2:0] t;
    begin
      expired = (t <= 3'h1);
    end
  endfunction

  function [2:0] count_down;
    input [2:0] t;
    begin
      count_down = t - 3'h1;
    end
  endfunction

  // Only the lowest data line carries the flag; the rest stay low
  function [15:0] flag_word;
    input b;
    begin
      flag_word = {15'h0000, b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= ST_INIT;
      cmd <= `DPSF_CMD_INIT;
      cnt <= 3'h0;
      timer <= 3'h0;
      do_read <= 1'b0;
      O_FLAG_SPACE_SELECT_N <= 1'b1;
      O_OE_N <= 1'b1;
      O_RW_N <= 1'b1;
      O_ADDR <= 3'h0;
      O_DATA_OUT <= 16'h0000;
      O_DATA_OE <= 1'b0;
      O_BUSY <= 1'b1;
      O_DONE <= 1'b0;
      O_GRANTED <= 1'b0;
      O_INIT_DONE <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      case (state)
        ST_INIT: begin
          // Latches come up undefined, so free every flag first [R15] [R16]
          O_ADDR <= cnt;
          O_DATA_OUT <= flag_word(1'b1);
          do_read <= 1'b0;
          timer <= cyc(`DPSF_SETUP_CYC);
          state <= ST_WSET;
        end
        ST_IDLE: begin
          // Requests are taken only here; one raised while busy is dropped
          O_BUSY <= 1'b0;
          if (I_REQ) begin
            O_BUSY <= 1'b1;
            cmd <= I_CMD;
            O_ADDR <= I_FLAG; // [R17]
            timer <= cyc(`DPSF_SETUP_CYC);
            if (I_CMD == `DPSF_CMD_POLL) begin
              state <= ST_RSET;
            end else if (I_CMD == `DPSF_CMD_INIT) begin
              cnt <= 3'h0;
              O_INIT_DONE <= 1'b0;
              state <= ST_INIT;
            end else begin
              // Acquire writes zero then reads back; release writes one [R5] [R11] [R20]
              O_DATA_OUT <= flag_word(I_CMD != `DPSF_CMD_ACQUIRE); // [R18]
              do_read <= (I_CMD == `DPSF_CMD_ACQUIRE);
              state <= ST_WSET;
            end
          end
        end
        ST_WSET: begin
          O_DATA_OE <= 1'b1;
          O_RW_N <= 1'b0;
          O_FLAG_SPACE_SELECT_N <= 1'b0; // [R17]
          if (expired(timer)) begin
            timer <= cyc(`DPSF_STROBE_CYC);
            state <= ST_WSTB;
          end else begin
            timer <= count_down(timer);
          end
        end
        ST_WSTB: begin
          if (expired(timer)) begin
            O_FLAG_SPACE_SELECT_N <= 1'b1;
            O_RW_N <= 1'b1;
            O_DATA_OE <= 1'b0;
            timer <= cyc(`DPSF_SETUP_CYC);
            state <= ST_GAP;
          end else begin
            timer <= count_down(timer);
          end
        end
        ST_RSET: begin
          // Fresh select and enable edge makes the device recapture [R2] [R4]
          O_FLAG_SPACE_SELECT_N <= 1'b0;
          O_OE_N <= 1'b0;
          timer <= cyc(`DPSF_STROBE_CYC + `DPSF_SYNC_CYC);
          state <= ST_RSTB;
        end
        ST_RSTB: begin
          // Extra sync cycles cover the synchroniser latency
          if (expired(timer)) begin
            O_GRANTED <= ~flag_bit; // [R1] [R6] [R19]
            O_FLAG_SPACE_SELECT_N <= 1'b1;
            O_OE_N <= 1'b1; // [R4]
            do_read <= 1'b0;
            timer <= cyc(`DPSF_SETUP_CYC);
            state <= ST_GAP;
          end else begin
            timer <= count_down(timer);
          end
        end
        ST_GAP: begin
          // Bus idles a cycle after each phase, so data drive never meets output enable
          if (expired(timer)) begin
            if (do_read) begin
              timer <= cyc(`DPSF_SETUP_CYC);
              state <= ST_RSET; // [R5]
            end else if (cmd == `DPSF_CMD_INIT && cnt != `DPSF_LAST_FLAG) begin
              cnt <= cnt + 3'h1;
              state <= ST_INIT;
            end else begin
              if (cmd == `DPSF_CMD_INIT) begin
                O_INIT_DONE <= 1'b1;
              end
              if (cmd == `DPSF_CMD_RELEASE || cmd == `DPSF_CMD_INIT) begin
                O_GRANTED <= 1'b0;
              end
              O_DONE <= 1'b1;
              state <= ST_IDLE;
            end
          end else begin
            timer <= count_down(timer);
          end
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end
endmodule // dpsf_host

//--- sim/dpsf_dev_model.sv
// Semaphore flag device model: left port on host pins, right port from bench
module dpsf_dev_model (
  input wire logic i_sel_n,
  input wire logic i_oe_n,
  input wire logic i_rw_n,
  input wire logic [2:0] i_addr,
  input wire logic i_d0,
  input wire logic i_rwr,
  input wire logic [2:0] i_raddr,
  input wire logic i_rd0,
  output logic [15:0] o_d,
  output logic o_rflag
);
  timeunit 1ns;
  timeprecision 1ns;
  // Junk power-up contents, some owned by the right side
  logic [7:0] lq = 8'h0F, rq = 8'hF0, ol = 8'h0F, orr = 8'hF0;
  logic lat = 1'b1;
  task automatic wr(input bit s, input logic [2:0] a, input logic d);
    begin
      if (s) rq[a] = d; else lq[a] = d;
      if (ol[a] && lq[a]) begin
        ol[a] = 1'b0;
        orr[a] = !rq[a];
      end
      if (orr[a] && rq[a]) begin
        orr[a] = 1'b0;
        ol[a] = !lq[a];
      end
      if (!ol[a] && !orr[a]) begin // Left checked first on a tie
        ol[a] = !lq[a];
        orr[a] = lq[a] && !rq[a];
      end
    end
  endtask
  always @(i_sel_n or i_rw_n or i_addr or i_d0) if (!i_sel_n && !i_rw_n) wr(0, i_addr, i_d0);
  always @(i_rwr or i_raddr or i_rd0) if (i_rwr) wr(1, i_raddr, i_rd0);
  always @(negedge (i_sel_n | i_oe_n)) lat = !ol[i_addr];
  // Released bus shows the inverse so a stale value cannot pass
  assign o_d = (!i_sel_n && !i_oe_n) ? {16{lat}} : {16{!lat}};
  assign o_rflag = !orr[i_raddr];
endmodule // dpsf_dev_model

//--- sim/dpsf_host_properties.sv
// Port checker for the semaphore host controller
module dpsf_host_properties (
  input wire I_CORE_CLK,
  input wire I_RSTN,
  input wire I_REQ,
  input wire O_FLAG_SPACE_SELECT_N,
  input wire O_OE_N,
  input wire O_RW_N,
  input wire [2:0] O_ADDR,
  input wire [15:0] O_DATA_OUT,
  input wire O_DATA_OE,
  input wire O_BUSY,
  input wire O_DONE,
  input wire O_INIT_DONE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  AST_DOE_WRITE: assert property (O_DATA_OE |-> !O_RW_N && O_OE_N) else $error("data driven outside write");
  AST_READ_SEL: assert property (!O_OE_N |-> !O_FLAG_SPACE_SELECT_N && O_RW_N) else $error("bad read");
  AST_POLL_GAP: assert property (!O_OE_N [*4] |=> O_OE_N) else $error("read not ended");
  AST_ADDR_HOLD: assert property (!O_FLAG_SPACE_SELECT_N [*2] |-> $stable(O_ADDR))
    else $error("address moved");
  AST_INIT_ONES: assert property (O_DATA_OE && !O_INIT_DONE |-> O_DATA_OUT[0]) else $error("init wrote zero");
  AST_TAKE: assert property (I_REQ && !O_BUSY |=> O_BUSY) else $error("request not taken");
  AST_DONE_PULSE: assert property (O_DONE |=> !O_DONE) else $error("done too long");
  AST_DONE_FREE: assert property (O_DONE |-> ##[0:1] !O_BUSY) else $error("busy after done");
endmodule // dpsf_host_properties
bind dpsf_host dpsf_host_properties u_props (.*);

//--- sim/test_dpsf_host.sv
// Testbench for the semaphore host controller
`include "dpsf_regs.vh"
module test_dpsf_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, req = 0, rwr = 0, rd0 = 1;
  logic [1:0] cmd = 0;
  logic [2:0] flag = 0, raddr = 0;
  wire [15:0] din, dout;
  wire sel_n, oe_n, rw_n, doe, busy, done, gnt, idn, rflag;
  wire [2:0] addr;
  integer bad_count = 0, checked = 0;
  dpsf_host uut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_REQ(req), .I_CMD(cmd), .I_FLAG(flag), .I_DATA_IN(din),
    .O_FLAG_SPACE_SELECT_N(sel_n), .O_OE_N(oe_n), .O_RW_N(rw_n), .O_ADDR(addr), .O_DATA_OUT(dout),
    .O_DATA_OE(doe), .O_BUSY(busy), .O_DONE(done), .O_GRANTED(gnt), .O_INIT_DONE(idn));
  dpsf_dev_model dev (.i_sel_n(sel_n), .i_oe_n(oe_n), .i_rw_n(rw_n), .i_addr(addr), .i_d0(dout[0]),
    .i_rwr(rwr), .i_raddr(raddr), .i_rd0(rd0), .o_d(din), .o_rflag(rflag));
  initial forever #25 clk = !clk;
  task chk(input string nm, input logic s, input logic e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %b seen %b", nm, e, s);
      end
    end
  endtask
  task run(input logic [1:0] c, input logic [2:0] f);
    integer n;
    begin
      @(negedge clk);
      req = 1; cmd = c; flag = f;
      @(negedge clk);
      req = 0;
      for (n = 0; n < 99 && done !== 1'b1; n++) @(negedge clk);
      chk("done", done, 1'b1);
    end
  endtask
  // Far processor writes one flag with a one-cycle write pulse; nothing is checked here
  task rw(input logic [2:0] a, input logic d);
    begin
      @(negedge clk);
      raddr = a; rd0 = d; rwr = 1;
      @(negedge clk);
      rwr = 0;
    end
  endtask
  task t_init;
    integer i;
    begin
      for (i = 0; i < 99 && idn !== 1'b1; i++) @(negedge clk);
      chk("init_done", idn, 1'b1);
      for (i = 0; i < 8; i++) rw(i[2:0], 1'b1);
    end
  endtask
  task t_free;
    begin
      raddr = 3'h2;
      run(`DPSF_CMD_ACQUIRE, 3'h2);
      chk("granted", gnt, 1'b1);
      chk("far flag", rflag, 1'b1);
      run(`DPSF_CMD_RELEASE, 3'h2);
      chk("granted", gnt, 1'b0);
      rw(3'h2, 1'b0);
      chk("far flag", rflag, 1'b0);
      rw(3'h2, 1'b1);
    end
  endtask
  task t_contend;
    begin
      rw(3'h5, 1'b0);
      run(`DPSF_CMD_ACQUIRE, 3'h5);
      chk("granted", gnt, 1'b0);
      rw(3'h5, 1'b1);
      run(`DPSF_CMD_POLL, 3'h5);
      chk("granted", gnt, 1'b1);
      chk("far flag", rflag, 1'b1);
      run(`DPSF_CMD_RELEASE, 3'h5);
      chk("far flag", rflag, 1'b1);
      rw(3'h5, 1'b0);
      chk("far flag", rflag, 1'b0);
      rw(3'h5, 1'b1);
    end
  endtask
  task t_withdraw;
    begin
      rw(3'h6, 1'b0);
      run(`DPSF_CMD_ACQUIRE, 3'h6);
      chk("granted", gnt, 1'b0);
      run(`DPSF_CMD_RELEASE, 3'h6);
      rw(3'h6, 1'b1);
      run(`DPSF_CMD_POLL, 3'h6);
      chk("granted", gnt, 1'b0);
    end
  endtask
  // Init command frees a flag the host holds
  task t_reinit;
    begin
      run(`DPSF_CMD_ACQUIRE, 3'h3);
      chk("granted", gnt, 1'b1);
      run(`DPSF_CMD_INIT, 3'h0);
      chk("init_done", idn, 1'b1);
      chk("granted", gnt, 1'b0);
      rw(3'h3, 1'b0);
      chk("far flag", rflag, 1'b0);
      rw(3'h3, 1'b1);
    end
  endtask
  task final_report;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    t_init;
    t_free;
    t_contend;
    t_withdraw;
    t_reinit;
    final_report;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    final_report;
  end
endmodule // test_dpsf_host
